// ==== inc/tsp_pkg.sv ====
package tsp_pkg;

  // Channel count, counter width and per-channel field width.
  localparam int NCH        = 4;
  localparam int CW         = 16;
  localparam int FW         = 4;
  localparam int REG_STRIDE = 4;

  // Register byte offsets.
  localparam logic [7:0] OFF_OUTCTL = 8'h00;
  localparam logic [7:0] OFF_MODE   = 8'h04;
  localparam logic [7:0] OFF_CMP0   = 8'h08;
  localparam logic [7:0] OFF_CAP0   = 8'h18;
  localparam logic [7:0] OFF_ISTAT  = 8'h28;
  localparam logic [7:0] OFF_IMASK  = 8'h2c;

  // Output control field, per channel at FW*k.
  localparam int OC_MODE  = 0;
  localparam int OC_POL   = 2;
  localparam int OC_FORCE = 3;

  // Sub-channel mode field, per channel at FW*k.
  localparam int MD_CCS = 0;
  localparam int MD_BUF = 1;
  localparam int MD_TBL = 2;
  localparam int MD_TBH = 3;

  // Interrupt status layout.
  localparam int IS_CAP = 0;
  localparam int IS_CMP = 4;

  // Reset values.
  localparam logic [15:0] OUTCTL_RST = 16'h8888;
  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [7:0]  IMASK_RST  = 8'h00;

  // Output modes.
  localparam logic [1:0] OM_TOG0 = 2'b00;
  localparam logic [1:0] OM_TOG1 = 2'b01;

  localparam logic [CW-1:0] CNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {TSP_B_FIRST, TSP_B_SECOND, TSP_B_CASC} tsp_base_t;

  function automatic tsp_base_t tsp_base_of(input logic hi, input logic lo);
    if (hi && lo) begin
      return TSP_B_CASC;
    end
    if (hi) begin
      return TSP_B_SECOND;
    end
    return TSP_B_FIRST;
  endfunction

  function automatic logic tsp_at(input logic [7:0] a, input logic [7:0] b,
                                  input int k);
    return a == b + 8'(REG_STRIDE * k);
  endfunction

endpackage

// ==== inc/tsp_if.sv ====
`timescale 1ns/1ps
interface tsp_if;
  import tsp_pkg::*;
  logic [CW-1:0]        count;
  logic                 sel_second;
  logic                 upd;
  logic [NCH-1:0][1:0]  mode;
  logic [NCH-1:0]       pol;
  logic [NCH-1:0]       force_on;
  logic [NCH-1:0]       set_trig;
  logic [NCH-1:0]       rst_trig;
  logic [NCH-1:0]       tog_trig;
  logic [NCH-1:0]       pin;
  modport mux  (output count, sel_second, upd);
  modport core (input count, sel_second, upd, pin,
                output mode, pol, force_on, set_trig, rst_trig, tog_trig);
  modport out  (input mode, pol, force_on, set_trig, rst_trig, tog_trig,
                output pin);
endinterface

// ==== design/tsp_mux_count.sv ====
`timescale 1ns/1ps
module tsp_mux_count
  import tsp_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // Time-base counters and strobes.
  input  wire logic [CW-1:0] first_time_base_counter_i,
  input  wire logic [CW-1:0] second_time_base_counter_i,
  input  wire logic          first_base_strobe_i,
  input  wire logic          second_base_strobe_i,
  // Shared count to the core.
  tsp_if.mux                 mx
);

  typedef struct packed {
    logic          prev0;
    logic          prev1;
    logic [CW-1:0] count;
    logic          sel;
    logic          upd;
  } tsp_mux_t;

  tsp_mux_t q;
  tsp_mux_t n;
  logic     rise0;
  logic     rise1;

  assign rise0 = first_base_strobe_i && !q.prev0;
  assign rise1 = second_base_strobe_i && !q.prev1;

  // A first-strobe edge wins when both rise together.
  always_comb begin
    n       = q;
    n.prev0 = first_base_strobe_i;
    n.prev1 = second_base_strobe_i;
    n.upd   = rise0 || rise1;
    if (rise0) begin
      n.count = first_time_base_counter_i;
      n.sel   = 1'b0;
    end else if (rise1) begin
      n.count = second_time_base_counter_i;
      n.sel   = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign mx.count      = q.count;
  assign mx.sel_second = q.sel;
  assign mx.upd        = q.upd;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_first_edge;
    rise0 |=> mx.upd && !mx.sel_second
              && mx.count == $past(first_time_base_counter_i);
  endproperty
  a_first_edge: assert property (p_first_edge)
    else $error("first strobe edge did not present first counter");

  property p_second_edge;
    !rise0 && rise1 |=> mx.upd && mx.sel_second
                        && mx.count == $past(second_time_base_counter_i);
  endproperty
  a_second_edge: assert property (p_second_edge)
    else $error("second strobe edge did not present second counter");

endmodule

// ==== design/tsp_out_stage.sv ====
`timescale 1ns/1ps
module tsp_out_stage
  import tsp_pkg::*;
(
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Controls and triggers in, pin levels out.
  tsp_if.out        o
);

  typedef struct packed {
    logic [NCH-1:0] act;
    logic [NCH-1:0] fprev;
    logic [NCH-1:0] pin;
  } tsp_out_t;

  localparam tsp_out_t OUT_RST = '{act: '0, fprev: '1, pin: '0};

  tsp_out_t q;
  tsp_out_t n;

  always_comb begin
    n       = q;
    n.fprev = o.force_on;
    for (int k = 0; k < NCH; k++) begin
      if (o.force_on[k]) begin
        n.act[k] = 1'b0;
      end else if (q.fprev[k]) begin
        n.act[k] = 1'b1;
      end else begin
        case (o.mode[k])
          OM_TOG1: begin
            if (o.rst_trig[k]) begin
              n.act[k] = 1'b0;
            end else if (o.set_trig[k]) begin
              n.act[k] = 1'b1;
            end
          end
          OM_TOG0: begin
            if (o.tog_trig[k]) begin
              n.act[k] = !q.act[k];
            end
          end
          default: begin
            n.act[k] = q.act[k];
          end
        endcase
      end
      n.pin[k] = n.act[k] ^ o.pol[k];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= OUT_RST;
    end else begin
      q <= n;
    end
  end

  assign o.pin = q.pin;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_pol_level;
    o.pin[0] == (q.act[0] ^ $past(o.pol[0]));
  endproperty
  a_pol_level: assert property (p_pol_level)
    else $error("pin level does not follow polarity and state");

  property p_force_hold;
    o.force_on[0] |=> !q.act[0] && o.pin[0] == $past(o.pol[0]);
  endproperty
  a_force_hold: assert property (p_force_hold)
    else $error("forced output not inactive");

  property p_release;
    !o.force_on[0] && q.fprev[0] |=> q.act[0];
  endproperty
  a_release: assert property (p_release)
    else $error("clearing force did not make output active");

  property p_t1_reset;
    !o.force_on[0] && !q.fprev[0] && o.mode[0] == OM_TOG1
      && o.rst_trig[0] |=> !q.act[0];
  endproperty
  a_t1_reset: assert property (p_t1_reset)
    else $error("reset trigger did not win");

  property p_t1_set;
    !o.force_on[0] && !q.fprev[0] && o.mode[0] == OM_TOG1
      && o.set_trig[0] && !o.rst_trig[0] |=> q.act[0];
  endproperty
  a_t1_set: assert property (p_t1_set)
    else $error("compare match did not set output active");

  property p_t0_toggle;
    !o.force_on[0] && !q.fprev[0] && o.mode[0] == OM_TOG0
      && o.tog_trig[0] |=> q.act[0] != $past(q.act[0]);
  endproperty
  a_t0_toggle: assert property (p_t0_toggle)
    else $error("toggle mode 0 match did not invert output");

  property p_no_trig_hold;
    !o.force_on[0] && !q.fprev[0] && !o.set_trig[0] && !o.rst_trig[0]
      && !o.tog_trig[0] |=> $stable(q.act[0]);
  endproperty
  a_no_trig_hold: assert property (p_no_trig_hold)
    else $error("output changed without a trigger");

  c_release: cover property (!o.force_on[0] && q.fprev[0]);
  c_t1_pulse: cover property (q.act[0] ##[1:50] !q.act[0]);

endmodule

// ==== design/tsp_timer_subch.sv ====
`timescale 1ns/1ps
module tsp_timer_subch
  import tsp_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  // APB slave.
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Time bases and capture events.
  input  wire logic [CW-1:0]       first_time_base_counter_i,
  input  wire logic [CW-1:0]       second_time_base_counter_i,
  input  wire logic                first_base_strobe_i,
  input  wire logic                second_base_strobe_i,
  input  wire logic [NCH-1:0]      capture_event_i,
  // Timer outputs.
  output logic      [NCH-1:0]      timer_output_pin_o,
  output logic      [1:0]          base_clear_o,
  output logic                     irq_o
);

  typedef struct packed {
    logic [15:0]                outctl;
    logic [15:0]                mode;
    logic [NCH-1:0][CW-1:0]     cmp;
    logic [NCH-1:0][2*CW-1:0]   cap;
    logic [NCH-1:0][2*CW-1:0]   buff;
    logic [NCH-1:0]             bfull;
    logic [CW-1:0]              base0;
    logic [CW-1:0]              base1;
    logic [7:0]                 stat;
    logic [7:0]                 mask;
    logic                       irq;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
    logic [NCH-1:0]             set_t;
    logic [NCH-1:0]             rst_t;
    logic [NCH-1:0]             tog_t;
    logic [1:0]                 clr;
  } tsp_core_t;

  localparam tsp_core_t CORE_RST = '{outctl: OUTCTL_RST, mode: MODE_RST,
                                     mask: IMASK_RST, default: '0};

  tsp_core_t q;
  tsp_core_t n;
  tsp_if     lnk ();
  logic      zero;
  logic      acc;
  logic      wr;
  logic      rd_done;

  tsp_mux_count u_mux (
    .clk_i                      (clk_i),
    .rst_n_i                    (rst_n_i),
    .first_time_base_counter_i  (first_time_base_counter_i),
    .second_time_base_counter_i (second_time_base_counter_i),
    .first_base_strobe_i        (first_base_strobe_i),
    .second_base_strobe_i       (second_base_strobe_i),
    .mx                         (lnk.mux)
  );

  tsp_out_stage u_out (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .o       (lnk.out)
  );

  assign zero = lnk.upd && !lnk.sel_second && lnk.count == CNT_ZERO;
  assign acc     = psel_i && penable_i;
  assign wr      = acc && q.pready && pwrite_i;
  assign rd_done = acc && q.pready && !pwrite_i;

  always_comb begin
    tsp_base_t     b;
    logic          hit;
    logic          ok;
    logic [31:0]   rdv;
    logic [2*CW-1:0] val;
    b         = TSP_B_FIRST;
    hit       = 1'b0;
    ok        = 1'b0;
    rdv       = '0;
    val       = '0;
    n         = q;
    n.set_t   = '0;
    n.rst_t   = '0;
    n.tog_t   = '0;
    n.clr     = '0;
    n.pready  = 1'b0;
    // Register decode; reads return the state sampled in the access cycle.
    if (tsp_at(paddr_i, OFF_OUTCTL, 0)) begin
      ok  = 1'b1;
      rdv = {16'h0000, q.outctl};
      if (wr) begin
        n.outctl = pwdata_i[15:0];
      end
    end
    if (tsp_at(paddr_i, OFF_MODE, 0)) begin
      ok  = 1'b1;
      rdv = {16'h0000, q.mode};
      if (wr) begin
        n.mode = pwdata_i[15:0];
      end
    end
    if (tsp_at(paddr_i, OFF_IMASK, 0)) begin
      ok  = 1'b1;
      rdv = {24'h000000, q.mask};
      if (wr) begin
        n.mask = pwdata_i[7:0];
      end
    end
    if (tsp_at(paddr_i, OFF_ISTAT, 0)) begin
      ok  = 1'b1;
      rdv = {24'h000000, q.stat};
      // Only the bits that were returned are cleared; later events survive.
      if (rd_done) begin
        n.stat = q.stat & ~q.prdata[7:0];
      end
    end
    for (int k = 0; k < NCH; k++) begin
      if (tsp_at(paddr_i, OFF_CMP0, k)) begin
        ok  = 1'b1;
        rdv = {16'h0000, q.cmp[k]};
        if (wr) begin
          n.cmp[k] = pwdata_i[CW-1:0];
        end
      end
      if (tsp_at(paddr_i, OFF_CAP0, k)) begin
        ok  = 1'b1;
        rdv = q.cap[k];
      end
    end
    if (acc && !q.pready) begin
      n.pready  = 1'b1;
      n.pslverr = !ok;
      n.prdata  = pwrite_i ? '0 : rdv;
    end
    if (lnk.upd) begin
      if (lnk.sel_second) begin
        n.base1 = lnk.count;
      end else begin
        n.base0 = lnk.count;
      end
    end
    // Sub-channels; event sets are applied after the read clear.
    for (int k = 0; k < NCH; k++) begin
      b   = tsp_base_of(q.mode[FW*k+MD_TBH], q.mode[FW*k+MD_TBL]);
      hit = lnk.upd && (lnk.sel_second == (b == TSP_B_SECOND))
            && lnk.count == q.cmp[k];
      if (q.mode[FW*k+MD_CCS]) begin
        if (hit) begin
          n.stat[IS_CMP+k] = 1'b1;
          if (q.outctl[FW*k+OC_MODE +: 2] == OM_TOG0) begin
            n.tog_t[k]            = 1'b1;
            n.clr[lnk.sel_second] = 1'b1;
          end else begin
            n.set_t[k] = 1'b1;
          end
        end
        if (zero && q.outctl[FW*k+OC_MODE +: 2] == OM_TOG1) begin
          n.rst_t[k] = 1'b1;
        end
      end else begin
        if (b == TSP_B_CASC) begin
          val = {q.base1, q.base0};
        end else if (b == TSP_B_SECOND) begin
          val = {16'h0000, q.base1};
        end else begin
          val = {16'h0000, q.base0};
        end
        if (q.bfull[k] && lnk.upd) begin
          n.cap[k]   = q.buff[k];
          n.bfull[k] = 1'b0;
        end
        if (capture_event_i[k]) begin
          if (q.mode[FW*k+MD_BUF] && b != TSP_B_CASC) begin
            n.buff[k]  = val;
            n.bfull[k] = 1'b1;
          end else begin
            n.cap[k] = val;
          end
          n.stat[IS_CAP+k] = 1'b1;
        end
      end
    end
    n.irq = |(n.stat & n.mask);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= CORE_RST;
    end else begin
      q <= n;
    end
  end

  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      lnk.mode[k]     = q.outctl[FW*k+OC_MODE +: 2];
      lnk.pol[k]      = q.outctl[FW*k+OC_POL];
      lnk.force_on[k] = q.outctl[FW*k+OC_FORCE];
    end
    lnk.set_trig = q.set_t;
    lnk.rst_trig = q.rst_t;
    lnk.tog_trig = q.tog_t;
  end

  assign prdata_o           = q.prdata;
  assign pready_o           = q.pready;
  assign pslverr_o          = q.pslverr;
  assign irq_o              = q.irq;
  assign base_clear_o       = q.clr;
  assign timer_output_pin_o = lnk.pin;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Sub-channels watched by the capture checks below.
  localparam int CH_PL = 1;
  localparam int CH_CA = 2;
  localparam int CH_BF = 3;

  property p_zero_reset;
    q.mode[MD_CCS] && q.outctl[OC_MODE +: 2] == OM_TOG1 && zero
      |=> q.rst_t[0];
  endproperty
  a_zero_reset: assert property (p_zero_reset)
    else $error("zero count did not raise reset trigger");

  property p_compare_no_cap;
    q.mode[MD_CCS] |=> $stable(q.cap[0]);
  endproperty
  a_compare_no_cap: assert property (p_compare_no_cap)
    else $error("capture register changed in compare mode");

  property p_plain_cap;
    !q.mode[FW*CH_PL+MD_CCS] && !q.mode[FW*CH_PL+MD_BUF]
      && !q.mode[FW*CH_PL+MD_TBH] && capture_event_i[CH_PL]
      |=> q.cap[CH_PL] == {16'h0000, $past(q.base0)};
  endproperty
  a_plain_cap: assert property (p_plain_cap)
    else $error("buffer-less capture value wrong");

  property p_buf_cap;
    !q.mode[FW*CH_BF+MD_CCS] && q.mode[FW*CH_BF+MD_BUF]
      && !q.mode[FW*CH_BF+MD_TBH] && !lnk.upd && capture_event_i[CH_BF]
      |=> q.bfull[CH_BF] && $stable(q.cap[CH_BF]);
  endproperty
  a_buf_cap: assert property (p_buf_cap)
    else $error("buffered capture bypassed the buffer");

  property p_casc_cap;
    !q.mode[FW*CH_CA+MD_CCS] && q.mode[FW*CH_CA+MD_TBH]
      && q.mode[FW*CH_CA+MD_TBL] && capture_event_i[CH_CA]
      |=> q.cap[CH_CA] == {$past(q.base1), $past(q.base0)};
  endproperty
  a_casc_cap: assert property (p_casc_cap)
    else $error("cascade capture value wrong");

  property p_t1_set_trig;
    q.mode[MD_CCS] && !q.mode[MD_TBH] && q.outctl[OC_MODE +: 2] == OM_TOG1
      && lnk.upd && !lnk.sel_second && lnk.count == q.cmp[0]
      |=> q.set_t[0];
  endproperty
  a_t1_set_trig: assert property (p_t1_set_trig)
    else $error("compare match did not raise set trigger");

  property p_t0_clear;
    q.mode[MD_CCS] && !q.mode[MD_TBH] && q.outctl[OC_MODE +: 2] == OM_TOG0
      && lnk.upd && !lnk.sel_second && lnk.count == q.cmp[0]
      |=> q.tog_t[0] && base_clear_o[0];
  endproperty
  a_t0_clear: assert property (p_t0_clear)
    else $error("toggle mode 0 match did not toggle and clear");

  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready stayed high for more than one cycle");

  property p_irq_level;
    irq_o == |(q.stat & q.mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt does not match unmasked status");

  c_casc: cover property (!q.mode[FW*CH_CA+MD_CCS]
                          && q.mode[FW*CH_CA+MD_TBH]
                          && q.mode[FW*CH_CA+MD_TBL]
                          && capture_event_i[CH_CA]);
  c_irq: cover property (q.irq ##[1:20] !q.irq);

endmodule

// ==== verification/tsp_load_model.sv ====
`timescale 1ns/1ps
module tsp_load_model
  import tsp_pkg::*;
(
  // Clock.
  input  wire logic                 clk_i,
  // Pins under load.
  input  wire logic [NCH-1:0]       pin_i,
  // Rising edges seen on each pin.
  output logic      [NCH-1:0][7:0]  rises_o
);
  logic [NCH-1:0]      last_q = '0;
  logic [NCH-1:0][7:0] cnt_q  = '0;

  assign rises_o = cnt_q;

  // The load only listens; it counts clean low-to-high steps per pin.
  always @(posedge clk_i) begin
    last_q <= pin_i;
    for (int k = 0; k < NCH; k++) begin
      if (pin_i[k] === 1'b1 && last_q[k] === 1'b0) begin
        cnt_q[k] <= cnt_q[k] + 8'h01;
      end
    end
  end
endmodule

// ==== verification/timer_subchannel_pwm_output_tb_top.sv ====
`timescale 1ns/1ps
module timer_subchannel_pwm_output_tb_top;
  import tsp_pkg::*;
  logic                clk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                psel_i = 1'b0;
  logic                penable_i = 1'b0;
  logic                pwrite_i = 1'b0;
  logic [7:0]          paddr_i = 8'h00;
  logic [31:0]         pwdata_i = 32'h0;
  logic [31:0]         prdata_o;
  logic                pready_o;
  logic                pslverr_o;
  logic [CW-1:0]       first_time_base_counter_i = 16'h0;
  logic [CW-1:0]       second_time_base_counter_i = 16'h0;
  logic                first_base_strobe_i = 1'b0;
  logic                second_base_strobe_i = 1'b0;
  logic [NCH-1:0]      capture_event_i = 4'h0;
  logic [NCH-1:0]      timer_output_pin_o;
  logic [1:0]          base_clear_o;
  logic                irq_o;
  logic [NCH-1:0][7:0] rises;
  int                  fail_count = 0;
  int                  n_tests = 0;
  int                  clr_cnt = 0;
  int                  clr1_cnt = 0;
  logic [31:0]         r;
  logic                e;
  logic [15:0]         a, b, c;
  logic [7:0]          r0;
  int                  c0;

  always #10 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (base_clear_o[0] === 1'b1) begin
      clr_cnt <= clr_cnt + 1;
    end
    if (base_clear_o[1] === 1'b1) begin
      clr1_cnt <= clr1_cnt + 1;
    end
  end

  tsp_timer_subch tsp_timer_subch_inst (.*);

  tsp_load_model tsp_load_model_inst (
    .clk_i   (clk_i),
    .pin_i   (timer_output_pin_o),
    .rises_o (rises)
  );

  function automatic logic [31:0] octl(input logic [1:0] m, input logic p,
                                       input logic f);
    return {16'h0, 12'h888, f, p, m};
  endfunction

  function automatic logic [31:0] pin_exp(input logic act, input logic p);
    return {31'h0, act ^ p};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= ad;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    // Values read right after an edge are the ones that edge sampled.
    while (pready_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 20) begin
      fail_count++;
      finish_test();
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
    settle();
  endtask

  task automatic strobe(input logic sec, input logic [15:0] v);
    @(posedge clk_i);
    if (sec) begin
      second_time_base_counter_i <= v;
      second_base_strobe_i       <= 1'b1;
    end else begin
      first_time_base_counter_i <= v;
      first_base_strobe_i       <= 1'b1;
    end
    @(posedge clk_i);
    first_base_strobe_i  <= 1'b0;
    second_base_strobe_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic pin0(input logic act, input logic p);
    check({31'h0, timer_output_pin_o[0]}, pin_exp(act, p));
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    fail_count++;
    finish_test();
  end

  initial begin
    void'($urandom(80));
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    check({28'h0, timer_output_pin_o}, 32'h0);
    apb(1'b0, OFF_OUTCTL, 32'h0);
    check(r, 32'h8888);
    apb(1'b0, OFF_MODE, 32'h0);
    check(r, 32'h0);
    apb(1'b0, OFF_IMASK, 32'h0);
    check(r, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    $display("reset and map test done");
    wr(OFF_MODE, 32'h2c01);
    wr(OFF_CMP0, 32'h5);
    wr(OFF_OUTCTL, octl(OM_TOG1, 1'b0, 1'b1));
    pin0(1'b0, 1'b0);
    wr(OFF_OUTCTL, octl(OM_TOG1, 1'b1, 1'b1));
    pin0(1'b0, 1'b1);
    wr(OFF_OUTCTL, octl(OM_TOG1, 1'b1, 1'b0));
    pin0(1'b1, 1'b1);
    wr(OFF_OUTCTL, octl(OM_TOG1, 1'b0, 1'b0));
    pin0(1'b1, 1'b0);
    $display("force and polarity test done");
    strobe(1'b0, 16'h0);
    pin0(1'b0, 1'b0);
    strobe(1'b1, 16'h5);
    pin0(1'b0, 1'b0);
    strobe(1'b0, 16'h5);
    pin0(1'b1, 1'b0);
    strobe(1'b0, 16'h3);
    pin0(1'b1, 1'b0);
    wr(OFF_OUTCTL, octl(OM_TOG1, 1'b0, 1'b1));
    pin0(1'b0, 1'b0);
    wr(OFF_OUTCTL, octl(OM_TOG1, 1'b0, 1'b0));
    pin0(1'b1, 1'b0);
    wr(OFF_CMP0, 32'h0);
    strobe(1'b0, 16'h0);
    pin0(1'b0, 1'b0);
    $display("toggle mode 1 test done");
    a = 16'($urandom());
    b = 16'($urandom());
    c = 16'($urandom());
    strobe(1'b0, a);
    strobe(1'b1, b);
    @(posedge clk_i);
    capture_event_i <= 4'hf;
    @(posedge clk_i);
    capture_event_i <= 4'h0;
    settle();
    check({31'h0, irq_o}, 32'h0);
    apb(1'b0, OFF_CAP0, 32'h0);
    check(r, 32'h0);
    apb(1'b0, OFF_CAP0 + 8'h04, 32'h0);
    check(r, {16'h0, a});
    apb(1'b0, OFF_CAP0 + 8'h08, 32'h0);
    check(r, {b, a});
    apb(1'b0, OFF_CAP0 + 8'h0c, 32'h0);
    check(r, 32'h0);
    strobe(1'b0, c);
    apb(1'b0, OFF_CAP0 + 8'h0c, 32'h0);
    check(r, {16'h0, a});
    wr(OFF_IMASK, 32'h2);
    check({31'h0, irq_o}, 32'h1);
    apb(1'b0, OFF_ISTAT, 32'h0);
    check(r, 32'h1e);
    settle();
    check({31'h0, irq_o}, 32'h0);
    apb(1'b0, OFF_ISTAT, 32'h0);
    check(r, 32'h0);
    $display("capture and interrupt test done");
    wr(OFF_OUTCTL, octl(OM_TOG0, 1'b0, 1'b1));
    wr(OFF_OUTCTL, octl(OM_TOG0, 1'b0, 1'b0));
    wr(OFF_CMP0, 32'h7);
    pin0(1'b1, 1'b0);
    r0 = rises[0];
    c0 = clr_cnt;
    strobe(1'b0, 16'h7);
    pin0(1'b0, 1'b0);
    check(32'(clr_cnt), 32'(c0 + 1));
    strobe(1'b0, 16'h7);
    pin0(1'b1, 1'b0);
    check({24'h0, rises[0]}, {24'h0, r0 + 8'h01});
    wr(OFF_OUTCTL, octl(2'h2, 1'b0, 1'b0));
    strobe(1'b0, 16'h7);
    pin0(1'b1, 1'b0);
    check(32'(clr_cnt), 32'(c0 + 2));
    check(32'(clr1_cnt), 32'h0);
    $display("toggle mode 0 and hold test done");
    finish_test();
  end
endmodule
